/* verif/spi_rx_fifo_read_port_tb.sv */
`timescale 1ns/1ps
module spi_rx_fifo_read_port_tb;
	import srxf_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_rdata, d;
	logic link_sclk, link_mosi;
	logic [2:0] link_sel;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	logic [2:0] r_pin [4] = '{3'h6, 3'h5, 3'h3, 3'h0};
	logic [15:0] r_dat [4] = '{16'hA5C3, 16'h8001, 16'h7FFE, 16'hFFFF};
	logic [31:0] r_exp [4] = '{32'h0016A5C3, 32'h00158001, 32'h00137FFE,
		32'h0010FFFF};

	srxf_top i_dut (.*);
	srxf_spi_master i_spi (.*);

	always #12.5 aclk = ~aclk;

	// ****
	// shared tasks
	// ****
	task end_of_test;
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			err_count++;
			end_of_test();
		end
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %0t: got %h want %h", $time, g, e);
		end
	endtask : chk

	// rready comes one edge late so the held answer is seen
	task rd(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		@(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task wr(input logic [11:0] a, input logic [31:0] v);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (s_axi_awready && s_axi_awvalid) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		@(posedge aclk);
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	// ****
	// main sequence
	// ****
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(SRXF_ADDR_PEEK);
		chk(d, 32'h0);
		for (int i = 0; i < 4; i++) begin
			i_spi.send(r_pin[i], r_dat[i], 16'h0000, 1, 3'h7);
			repeat (8) @(posedge aclk);
			rd(SRXF_ADDR_PEEK);
			chk(d, r_exp[i]);
			rd(SRXF_ADDR_STAT);
			chk(d, 32'h00000100);
			rd(SRXF_ADDR_POP);
			chk(d, r_exp[i]);
			rd(SRXF_ADDR_PEEK);
			chk(d, 32'h0);
		end
		i_spi.send(3'h6, 16'h1234, 16'hABCD, 2, 3'h7);
		repeat (8) @(posedge aclk);
		rd(SRXF_ADDR_POP);
		chk(d, 32'h00161234);
		rd(SRXF_ADDR_POP);
		chk(d, 32'h0006ABCD);
		rd(SRXF_ADDR_POP);
		chk({d[29:0], rs}, {30'h0, SRXF_RESP_OKAY});
		rd(12'h008);
		chk({d[29:0], rs}, {30'h0, SRXF_RESP_SLVERR});
		wr(SRXF_ADDR_POP, 32'h0);
		chk({30'h0, rs}, {30'h0, SRXF_RESP_SLVERR});
		wr(SRXF_ADDR_CFG, 32'h1);
		chk({30'h0, rs}, {30'h0, SRXF_RESP_OKAY});
		rd(SRXF_ADDR_CFG);
		chk(d, 32'h00000001);
		i_spi.send(3'h7, 16'h0F0F, 16'h0000, 1, 3'h6);
		repeat (8) @(posedge aclk);
		rd(SRXF_ADDR_POP);
		chk(d, 32'h00160F0F);
		// ten words into eight places: two dropped, overflow set
		for (int i = 0; i < 5; i++) begin
			i_spi.send(3'h7, 16'h1111, 16'h2222, 2, 3'h6);
			repeat (4) @(posedge aclk);
		end
		rd(SRXF_ADDR_STAT);
		chk(d, 32'h00000806);
		wr(SRXF_ADDR_STAT, 32'h00000004);
		rd(SRXF_ADDR_STAT);
		chk(d, 32'h00000802);
		rd(SRXF_ADDR_POP);
		chk(d, 32'h00161111);
		// reset in mid-run empties the FIFO and clears polarity
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(SRXF_ADDR_STAT);
		chk(d, 32'h00000001);
		rd(SRXF_ADDR_CFG);
		chk(d, 32'h00000000);
		end_of_test();
	end
endmodule : spi_rx_fifo_read_port_tb

/* verif/srxf_monitor.sv */
`timescale 1ns/1ps
module srxf_monitor
	import srxf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_ar;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_r_done;
		s_axi_rvalid && s_axi_rready;
	endsequence
	chk_rd_answer: assert property (s_ar |=> s_axi_rvalid)
		else $error("read answer late");
	chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
	chk_wr_answer: assert property (s_wr |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("response moved");
	chk_resv_zero: assert property (s_axi_rvalid |->
		s_axi_rdata[31:21] == 11'h000 && !s_axi_rdata[19])
		else $error("reserved bits set");
	chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while busy");
	chk_ar_back: assert property (s_r_done |=>
		!s_axi_rvalid ##1 s_axi_arready) else $error("read port stuck");
	chk_rst_quiet: assert property ($rose(aresetn) |->
		!s_axi_rvalid && !s_axi_bvalid) else $error("busy after reset");
endmodule : srxf_monitor

bind srxf_top srxf_monitor i_mon (.*);

/* verif/srxf_spi_master.sv */
`timescale 1ns/1ps
module srxf_spi_master (
	output logic link_sclk,
	output logic link_mosi,
	output logic [2:0] link_sel
);
	initial begin
		link_sclk = 1'b0;
		link_mosi = 1'b0;
		link_sel = 3'h7;
	end
	// sclk runs only inside a frame; selects held until push is sampled
	task send(input logic [2:0] act, input logic [15:0] w0,
		input logic [15:0] w1, input int n, input logic [2:0] idle);
		link_sel = act;
		#20;
		for (int k = 0; k < n; k++) begin
			for (int b = 15; b >= 0; b--) begin
				link_mosi = (k == 0) ? w0[b] : w1[b];
				#3 link_sclk = 1'b1;
				#3 link_sclk = 1'b0;
			end
		end
		link_mosi = ~link_mosi;
		#200 link_sel = idle;
	endtask : send
endmodule : srxf_spi_master

/* verilog/srxf_link_rx.sv */
`timescale 1ns/1ps
module srxf_link_rx
	import srxf_pkg::*;
(
	input wire logic link_sclk,
	input wire logic link_rst,
	input wire logic link_idle,
	input wire logic link_mosi,
	output logic [SRXF_DATA_W-1:0] word_r,
	output logic word_tgl_r
);

	// ****************************************
	// bit shifter on the link clock
	// ****************************************
	logic [SRXF_DATA_W-2:0] shift_r;
	logic [SRXF_DATA_W-2:0] shift_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic [SRXF_DATA_W-1:0] word_nxt;
	logic word_tgl_nxt;

	always_comb begin
		shift_nxt = {shift_r[SRXF_DATA_W-3:0], link_mosi};
		cnt_nxt = cnt_r + 4'h1;
		word_nxt = word_r;
		word_tgl_nxt = word_tgl_r;
		if (cnt_r == 4'hF) begin
			word_nxt = {shift_r, link_mosi};
			word_tgl_nxt = ~word_tgl_r;
		end
	end

	// the link clock stops between frames, so idle clears the bit count
	always_ff @(posedge link_sclk or posedge link_idle) begin
		if (link_idle) begin
			cnt_r <= 4'h0;
			shift_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
		end
	end

	// toggle must start known or every push after reset is unknown;
	// it is only reset with the bus side, never by idle, so no false push
	always_ff @(posedge link_sclk or posedge link_rst) begin
		if (link_rst) begin
			word_tgl_r <= 1'b0;
		end else begin
			word_tgl_r <= word_tgl_nxt;
		end
	end

	// word holds until the next whole word
	always_ff @(posedge link_sclk) begin
		word_r <= word_nxt;
	end

endmodule : srxf_link_rx

/* verilog/srxf_pkg.sv */
package srxf_pkg;

	// ****************************************
	// widths and field positions
	// ****************************************
	localparam int unsigned SRXF_DATA_W = 16;
	localparam int unsigned SRXF_NSEL = 3;
	localparam int unsigned SRXF_DEPTH = 8;
	localparam int unsigned SRXF_DATA_LSB = 0;
	localparam int unsigned SRXF_SEL_LSB = 16;
	localparam int unsigned SRXF_SOT_BIT = 20;
	localparam int unsigned SRXF_EMPTY_BIT = 0;
	localparam int unsigned SRXF_FULL_BIT = 1;
	localparam int unsigned SRXF_OVF_BIT = 2;
	localparam int unsigned SRXF_LEVEL_LSB = 8;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [11:0] SRXF_ADDR_CFG = 12'h000;
	localparam logic [11:0] SRXF_ADDR_STAT = 12'h004;
	localparam logic [11:0] SRXF_ADDR_POP = 12'hE30;
	localparam logic [11:0] SRXF_ADDR_PEEK = 12'hE40;

	// ****************************************
	// reset values and bus codes
	// ****************************************
	localparam logic [2:0] SRXF_POL_RST = 3'h0;
	localparam logic SRXF_SOT_RST = 1'b1;
	localparam logic [1:0] SRXF_RESP_OKAY = 2'h0;
	localparam logic [1:0] SRXF_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic transfer_first_flag;
		logic [2:0] sel_n;
		logic [15:0] data;
	} srxf_entry_s;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] data;
	} srxf_wreq_s;

	function automatic logic [31:0] srxf_word(input srxf_entry_s e);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[SRXF_DATA_LSB +: SRXF_DATA_W] = e.data;
		w[SRXF_SEL_LSB +: SRXF_NSEL] = e.sel_n;
		w[SRXF_SOT_BIT] = e.transfer_first_flag;
		return w;
	endfunction : srxf_word

endpackage : srxf_pkg

/* verilog/srxf_top.sv */
`timescale 1ns/1ps
module srxf_top
	import srxf_pkg::*;
#(
	parameter int unsigned DEPTH = SRXF_DEPTH
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic link_sclk,
	input wire logic link_mosi,
	input wire logic [SRXF_NSEL-1:0] link_sel
);

	localparam int unsigned AW = $clog2(DEPTH);

	// ****************************************
	// link side and crossing
	// ****************************************
	logic [SRXF_NSEL-1:0] select_polarity_bit_r;
	logic [SRXF_NSEL-1:0] sel_raw_n;
	logic link_idle;
	logic link_rst_r;
	logic [SRXF_DATA_W-1:0] link_word;
	logic link_tgl;

	assign sel_raw_n = link_sel ^ select_polarity_bit_r;
	assign link_idle = &sel_raw_n;

	srxf_link_rx u_link (
		.link_sclk(link_sclk),
		.link_rst(link_rst_r),
		.link_idle(link_idle),
		.link_mosi(link_mosi),
		.word_r(link_word),
		.word_tgl_r(link_tgl)
	);

	logic [SRXF_NSEL-1:0] sel_s1_r;
	logic [SRXF_NSEL-1:0] sel_s2_r;
	logic [SRXF_NSEL-1:0] sel_sync_n;
	logic tgl_s1_r;
	logic tgl_s2_r;
	logic tgl_s3_r;
	logic push;

	// link reset release is unsynchronised: the link clock stands in reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_rst_r <= 1'b1;
			sel_s1_r <= '1;
			sel_s2_r <= '1;
			tgl_s1_r <= 1'b0;
			tgl_s2_r <= 1'b0;
			tgl_s3_r <= 1'b0;
		end else begin
			link_rst_r <= 1'b0;
			sel_s1_r <= link_sel;
			sel_s2_r <= sel_s1_r;
			tgl_s1_r <= link_tgl;
			tgl_s2_r <= tgl_s1_r;
			tgl_s3_r <= tgl_s2_r;
		end
	end

	assign push = tgl_s2_r ^ tgl_s3_r;
	assign sel_sync_n = sel_s2_r ^ select_polarity_bit_r;

	// ****************************************
	// start-of-transfer tracking
	// ****************************************
	logic ended_r;
	logic ended_nxt;
	srxf_entry_s new_entry;

	always_comb begin
		ended_nxt = (&sel_sync_n) | (ended_r & ~push);
		new_entry.data = link_word;
		new_entry.sel_n = sel_sync_n;
		new_entry.transfer_first_flag = ended_r;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ended_r <= SRXF_SOT_RST;
		end else begin
			ended_r <= ended_nxt;
		end
	end

	// ****************************************
	// receive FIFO
	// ****************************************
	srxf_entry_s mem_r [DEPTH];
	logic [AW-1:0] wptr_r;
	logic [AW-1:0] wptr_nxt;
	logic [AW-1:0] rptr_r;
	logic [AW-1:0] rptr_nxt;
	logic [AW:0] level_r;
	logic [AW:0] level_nxt;
	logic ovf_r;
	logic ovf_nxt;
	logic pop;
	logic do_push;
	logic ovf_clr;
	logic empty;
	logic full;
	srxf_entry_s head;

	assign empty = (level_r == '0);
	assign full = (level_r == (AW + 1)'(DEPTH));
	assign head = mem_r[rptr_r];
	assign do_push = push & ~full;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		return (p == (AW)'(DEPTH - 1)) ? '0 : p + (AW)'(1);
	endfunction : ptr_inc

	always_comb begin
		wptr_nxt = do_push ? ptr_inc(wptr_r) : wptr_r;
		rptr_nxt = pop ? ptr_inc(rptr_r) : rptr_r;
		level_nxt = level_r;
		if (do_push && !pop) begin
			level_nxt = level_r + (AW + 1)'(1);
		end else if (pop && !do_push) begin
			level_nxt = level_r - (AW + 1)'(1);
		end
		// a drop in the clearing cycle still sets the flag
		ovf_nxt = (push & full) | (ovf_r & ~ovf_clr);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wptr_r <= '0;
			rptr_r <= '0;
			level_r <= '0;
			ovf_r <= 1'b0;
		end else begin
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
			level_r <= level_nxt;
			ovf_r <= ovf_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (do_push) begin
			mem_r[wptr_r] <= new_entry;
		end
	end

	// ****************************************
	// AXI4-Lite write path
	// ****************************************
	srxf_wreq_s wreq_r;
	srxf_wreq_s wreq_nxt;
	logic aw_got_r;
	logic aw_got_nxt;
	logic w_got_r;
	logic w_got_nxt;
	logic awready_nxt;
	logic wready_nxt;
	logic bvalid_nxt;
	logic [1:0] bresp_nxt;
	logic [SRXF_NSEL-1:0] pol_nxt;
	logic wr_fire;

	always_comb begin
		wreq_nxt = wreq_r;
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		bvalid_nxt = s_axi_bvalid & ~s_axi_bready;
		bresp_nxt = s_axi_bresp;
		pol_nxt = select_polarity_bit_r;
		ovf_clr = 1'b0;
		wr_fire = 1'b0;
		if (s_axi_awvalid && s_axi_awready) begin
			wreq_nxt.addr = s_axi_awaddr;
			aw_got_nxt = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wreq_nxt.data = s_axi_wdata;
			w_got_nxt = 1'b1;
		end
		if (aw_got_r && w_got_r && !s_axi_bvalid) begin
			wr_fire = 1'b1;
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = SRXF_RESP_OKAY;
			unique case (wreq_r.addr)
				SRXF_ADDR_CFG: begin
					pol_nxt = wreq_r.data[SRXF_NSEL-1:0];
				end
				SRXF_ADDR_STAT: begin
					ovf_clr = wreq_r.data[SRXF_OVF_BIT];
				end
				SRXF_ADDR_POP, SRXF_ADDR_PEEK: begin
					bresp_nxt = SRXF_RESP_SLVERR;
				end
				default: begin
					bresp_nxt = SRXF_RESP_SLVERR;
				end
			endcase
		end
		awready_nxt = ~aw_got_nxt & ~wr_fire;
		wready_nxt = ~w_got_nxt & ~wr_fire;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wreq_r <= '0;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= SRXF_RESP_OKAY;
			select_polarity_bit_r <= SRXF_POL_RST;
		end else begin
			wreq_r <= wreq_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			s_axi_awready <= awready_nxt;
			s_axi_wready <= wready_nxt;
			s_axi_bvalid <= bvalid_nxt;
			s_axi_bresp <= bresp_nxt;
			select_polarity_bit_r <= pol_nxt;
		end
	end

	// ****************************************
	// AXI4-Lite read path
	// ****************************************
	logic arready_nxt;
	logic rvalid_nxt;
	logic [31:0] rdata_nxt;
	logic [1:0] rresp_nxt;

	always_comb begin
		rvalid_nxt = s_axi_rvalid & ~s_axi_rready;
		rdata_nxt = s_axi_rdata;
		rresp_nxt = s_axi_rresp;
		pop = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = SRXF_RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			unique case (s_axi_araddr)
				SRXF_ADDR_CFG: begin
					rdata_nxt[SRXF_NSEL-1:0] = select_polarity_bit_r;
				end
				SRXF_ADDR_STAT: begin
					rdata_nxt[SRXF_EMPTY_BIT] = empty;
					rdata_nxt[SRXF_FULL_BIT] = full;
					rdata_nxt[SRXF_OVF_BIT] = ovf_r;
					rdata_nxt[SRXF_LEVEL_LSB +: AW + 1] = level_r;
				end
				SRXF_ADDR_POP: begin
					if (!empty) begin
						rdata_nxt = srxf_word(head);
						pop = 1'b1;
					end
				end
				SRXF_ADDR_PEEK: begin
					if (!empty) begin
						rdata_nxt = srxf_word(head);
					end
				end
				default: begin
					rresp_nxt = SRXF_RESP_SLVERR;
				end
			endcase
		end
		arready_nxt = ~rvalid_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= SRXF_RESP_OKAY;
		end else begin
			s_axi_arready <= arready_nxt;
			s_axi_rvalid <= rvalid_nxt;
			s_axi_rdata <= rdata_nxt;
			s_axi_rresp <= rresp_nxt;
		end
	end

endmodule : srxf_top
